/* logic/gps_regs.svh */
// Register offsets, field positions, reset values and constants of the group selector
`ifndef GPS_REGS_SVH
`define GPS_REGS_SVH

// ---------------------------------------------------------------
// Register offsets (byte addresses)
// ---------------------------------------------------------------
`define GPS_ADDR_W 4
`define GPS_OFF_CTRL 4'h0
`define GPS_OFF_FORCE 4'h4
`define GPS_OFF_REMOTE 4'h8
`define GPS_OFF_STATUS 4'hc

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define GPS_CTRL_FORCE_EN_BIT 0
`define GPS_CTRL_USED_LSB 4
`define GPS_CTRL_USED_MSB 6
`define GPS_STAT_ACTIVE_LSB 0
`define GPS_STAT_ACTIVE_MSB 2
`define GPS_STAT_FAIL_CFG_BIT 8
`define GPS_STAT_FAIL_PRIO_BIT 9
`define GPS_STAT_FAIL_FORCE_BIT 10

// ---------------------------------------------------------------
// Reset values and codes
// ---------------------------------------------------------------
`define GPS_GROUP_NONE 4'h0
`define GPS_USED_RESET 3'h0
`define GPS_ACTIVE_RESET 3'h0
`define GPS_FORCE_EN_RESET 1'h0

`endif

/* logic/gps_pkg.sv */
// Types shared by the group priority selector
package gps_pkg;

    // Number of parameter groups and width of a group index
    localparam int GPS_GROUPS = 8;
    typedef logic [2:0] gps_index_t;
    typedef logic [3:0] gps_code_t;
    typedef logic [GPS_GROUPS-1:0] gps_mask_t;

    // Who currently owns the active group
    typedef enum logic [1:0] {
        GPS_MODE_IDLE,
        GPS_MODE_AUTO,
        GPS_MODE_FORCED
    } gps_mode_e;

endpackage

/* logic/gps_selector.sv */
// Parameter group priority selector with force and remote change
//
// What this block does
// R01: Eight groups, exactly one reported active.
// R02: Reset: group one only, selection idle.
// R03: Several enabled groups: requests pick active.
// R04: Force on: forced group replaces automatic selection.
// R05: Forced group None or one..eight, configured only; the code refuses a write of None.
// R06: After force off, forced group stays.
// R07: Force enable resets off; forced writes need it.
// R08: Operator enables target and force first.
// R09: Request inputs may be pulses or levels.
// R10: Fixed priority, group one highest.
// R11: Two held levels: higher priority active.
// R12: Pulse selection persists until another request.
// R13: Held group one blocks all others.
// R14: Held group N blocks only lower groups.
// R15: Held group eight blocks nothing.
// R16: Remote change None..eight, refused when blocked.
// R17: Used groups from one; new groups default.
// R18: Active status one..eight, group one after reset.
// R19: Force off with held levels resumes automatic.
// R20: Flag requests to unconfigured groups, except while force is on.
// R21: Flag requests refused by higher held group.
// R22: Rising edge per input is one event.
//
// Local design decisions: strobed register access and the register addresses.
`timescale 1ns/1ps

`include "gps_regs.svh"

module gps_selector
    import gps_pkg::*;
#(
    parameter int GROUPS = 8
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [`GPS_ADDR_W-1:0] bus_addr,
    input wire logic [31:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [31:0] bus_rdata,
    input wire logic [GROUPS-1:0] group_req_in,
    output logic [2:0] active_group,
    output logic [GROUPS-1:0] group_enabled,
    output logic [GROUPS-1:0] load_defaults,
    output logic fail_unconfigured,
    output logic fail_priority,
    output logic fail_force
);

    // ---------------------------------------------------------------
    // Helper functions
    // ---------------------------------------------------------------

    // Lowest set bit wins: group one has top priority
    function automatic gps_index_t lowest_index(input gps_mask_t m);
        gps_index_t idx;
        idx = 3'h0;
        for (int i = GPS_GROUPS - 1; i >= 0; i--) begin
            if (m[i]) begin
                idx = 3'(i);
            end
        end
        return idx;
    endfunction

    // Groups blocked by held levels of higher priority
    function automatic gps_mask_t blocked_by(input gps_mask_t held);
        gps_mask_t b;
        b = '0;
        for (int j = 1; j < GPS_GROUPS; j++) begin
            for (int i = 0; i < j; i++) begin
                if (held[i]) begin
                    b[j] = 1'b1;
                end
            end
        end
        return b;
    endfunction

    // Enabled mask from a used-groups count minus one
    function automatic gps_mask_t used_mask(input gps_index_t used);
        gps_mask_t m;
        m = '0;
        for (int i = 0; i < GPS_GROUPS; i++) begin
            m[i] = (3'(i) <= used);
        end
        return m;
    endfunction

    // ---------------------------------------------------------------
    // Request input synchroniser and edge detection
    // ---------------------------------------------------------------
    gps_mask_t req_meta_reg;
    gps_mask_t req_sync_reg;
    gps_mask_t req_prev_reg;
    gps_mask_t req_edge;

    // Two flops per pin before any logic looks at it
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            req_meta_reg <= '0;
            req_sync_reg <= '0;
            req_prev_reg <= '0;
        end else begin
            req_meta_reg <= group_req_in;
            req_sync_reg <= req_meta_reg;
            req_prev_reg <= req_sync_reg;
        end
    end

    // One event per rising edge
    assign req_edge = req_sync_reg & ~req_prev_reg; // see R22, R09

    // ---------------------------------------------------------------
    // Register bus decode
    // ---------------------------------------------------------------
    logic force_en_reg;
    gps_index_t used_reg;
    gps_code_t force_group_reg;
    gps_code_t remote_group_reg;
    gps_index_t active_reg;
    gps_mask_t enabled;
    logic wr_ctrl;
    logic wr_force;
    logic wr_remote;
    gps_code_t wcode;
    logic force_ok;

    assign wr_ctrl = bus_wr && (bus_addr == `GPS_OFF_CTRL);
    assign wr_force = bus_wr && (bus_addr == `GPS_OFF_FORCE);
    assign wr_remote = bus_wr && (bus_addr == `GPS_OFF_REMOTE);
    assign wcode = bus_wdata[3:0];
    assign enabled = used_mask(used_reg);

    // Forced write accepted only with force on and a configured target
    assign force_ok = force_en_reg && (wcode != `GPS_GROUP_NONE) && (wcode <= 4'h8)
        && enabled[3'(wcode - 4'h1)]; // see R05, R07, R08

    // Control register: force enable and used-groups count
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            force_en_reg <= `GPS_FORCE_EN_RESET; // see R07
            used_reg <= `GPS_USED_RESET; // see R02, R17
        end else if (wr_ctrl) begin
            force_en_reg <= bus_wdata[`GPS_CTRL_FORCE_EN_BIT];
            used_reg <= bus_wdata[`GPS_CTRL_USED_MSB:`GPS_CTRL_USED_LSB];
        end
    end

    // Forced group: taken only while forcing is allowed
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            force_group_reg <= `GPS_GROUP_NONE; // see R05
        end else if (wr_force && force_ok) begin
            force_group_reg <= wcode; // see R07
        end
    end

    // Remote change value None..eight, read back as written
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            remote_group_reg <= `GPS_GROUP_NONE; // see R16
        end else if (wr_remote && (wcode <= 4'h8)) begin
            remote_group_reg <= wcode;
        end
    end

    // ---------------------------------------------------------------
    // Selection logic
    // ---------------------------------------------------------------
    gps_mode_e mode;
    gps_mask_t remote_req;
    gps_mask_t all_req;
    gps_mask_t blocked;
    gps_mask_t winners;
    gps_index_t active_next;

    // Remote write becomes a one-cycle request for its group
    always_comb begin
        remote_req = '0;
        if (wr_remote && (wcode != `GPS_GROUP_NONE) && (wcode <= 4'h8)) begin
            remote_req[3'(wcode - 4'h1)] = 1'b1;
        end
    end

    // Held levels request continuously, edges and remote once
    assign all_req = req_sync_reg | req_edge | remote_req; // see R09, R12
    assign blocked = blocked_by(req_sync_reg); // see R13, R14, R15, R16
    assign winners = all_req & enabled & ~blocked; // see R10, R11

    // Mode of operation
    always_comb begin
        if (force_en_reg) begin
            mode = GPS_MODE_FORCED;
        end else if (used_reg == 3'h0) begin
            mode = GPS_MODE_IDLE;
        end else begin
            mode = GPS_MODE_AUTO;
        end
    end

    // Next active group
    always_comb begin
        active_next = active_reg; // see R06, R12
        case (mode)
            GPS_MODE_IDLE: begin
                active_next = 3'h0; // see R02
            end
            GPS_MODE_FORCED: begin
                if (force_group_reg != `GPS_GROUP_NONE) begin
                    active_next = 3'(force_group_reg - 4'h1); // see R04
                end
            end
            GPS_MODE_AUTO: begin
                if (|winners) begin
                    active_next = lowest_index(winners); // see R03, R10, R19
                end else if (!enabled[active_reg]) begin
                    active_next = 3'h0;
                end
            end
            default: begin
                active_next = 3'h0;
            end
        endcase
    end

    // Active group register
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            active_reg <= `GPS_ACTIVE_RESET; // see R18
        end else begin
            active_reg <= active_next; // see R01
        end
    end

    // ---------------------------------------------------------------
    // Failure flags and group enable outputs
    // ---------------------------------------------------------------
    logic fail_cfg_reg;
    logic fail_prio_reg;
    logic fail_force_reg;
    gps_mask_t enabled_reg;
    gps_mask_t load_reg;

    // Level flags follow the requests that cause them
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            fail_cfg_reg <= 1'b0;
            fail_prio_reg <= 1'b0;
        end else begin
            fail_cfg_reg <= (mode != GPS_MODE_FORCED)
                && |(all_req & ~enabled); // see R20
            fail_prio_reg <= (mode == GPS_MODE_AUTO)
                && |(all_req & enabled & blocked); // see R21, R16
        end
    end

    // Refused forced write sets, accepted one clears; set wins
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            fail_force_reg <= 1'b0;
        end else if (wr_force && !force_ok) begin
            fail_force_reg <= 1'b1; // see R07
        end else if (wr_force) begin
            fail_force_reg <= 1'b0;
        end
    end

    // Enabled mask and one-cycle default load for new groups
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            enabled_reg <= 8'h01;
            load_reg <= '0;
        end else begin
            enabled_reg <= enabled;
            load_reg <= enabled & ~enabled_reg; // see R17
        end
    end

    // ---------------------------------------------------------------
    // Read data
    // ---------------------------------------------------------------
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;

    // Unmapped offsets read as zero
    always_comb begin
        rdata_next = 32'h0000_0000;
        case (bus_addr)
            `GPS_OFF_CTRL: begin
                rdata_next[`GPS_CTRL_FORCE_EN_BIT] = force_en_reg;
                rdata_next[`GPS_CTRL_USED_MSB:`GPS_CTRL_USED_LSB] = used_reg;
            end
            `GPS_OFF_FORCE: begin
                rdata_next[3:0] = force_group_reg;
            end
            `GPS_OFF_REMOTE: begin
                rdata_next[3:0] = remote_group_reg;
            end
            `GPS_OFF_STATUS: begin
                rdata_next[`GPS_STAT_ACTIVE_MSB:`GPS_STAT_ACTIVE_LSB] = active_reg;
                rdata_next[`GPS_STAT_FAIL_CFG_BIT] = fail_cfg_reg;
                rdata_next[`GPS_STAT_FAIL_PRIO_BIT] = fail_prio_reg;
                rdata_next[`GPS_STAT_FAIL_FORCE_BIT] = fail_force_reg;
            end
            default: begin
                rdata_next = 32'h0000_0000;
            end
        endcase
    end

    // Read data stands in the cycle after the strobe
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rdata_reg <= 32'h0000_0000;
        end else if (bus_rd) begin
            rdata_reg <= rdata_next;
        end else begin
            rdata_reg <= 32'h0000_0000;
        end
    end

    assign bus_rdata = rdata_reg;
    assign active_group = active_reg;
    assign group_enabled = enabled_reg;
    assign load_defaults = load_reg;
    assign fail_unconfigured = fail_cfg_reg;
    assign fail_priority = fail_prio_reg;
    assign fail_force = fail_force_reg;

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    a_idle_group_one: assert property ( // see R02
        (used_reg == 3'h0 && !force_en_reg) |=> active_reg == 3'h0)
        else $error("Idle selector left group one");

    // A control write may shrink the used count under the active group for one cycle
    a_active_enabled: assert property ( // see R01
        (!force_en_reg && !wr_ctrl) |=> enabled[active_reg] || $past(force_en_reg))
        else $error("Active group not enabled");

    a_force_takes: assert property ( // see R04
        (force_en_reg && force_group_reg != 4'h0)
            |=> active_reg == 3'($past(force_group_reg) - 4'h1))
        else $error("Forced group not made active");

    a_force_refused: assert property ( // see R07
        (wr_force && !force_en_reg) |=> $stable(force_group_reg) && fail_force_reg)
        else $error("Forced write taken while force off");

    a_group_one_held: assert property ( // see R13
        (mode == GPS_MODE_AUTO && req_sync_reg[0]) |=> active_reg == 3'h0)
        else $error("Held group one not active");

    a_pulse_persists: assert property ( // see R12
        (mode == GPS_MODE_AUTO && winners == 8'h00 && enabled[active_reg])
            |=> $stable(active_reg))
        else $error("Active group changed without request");

    a_priority_win: assert property ( // see R10
        (mode == GPS_MODE_AUTO && all_req[0] && |all_req[7:1]) |=> active_reg == 3'h0)
        else $error("Lower priority request won");

    a_blocked_flag: assert property ( // see R21
        (mode == GPS_MODE_AUTO && req_sync_reg[1] && req_edge[4] && enabled[4])
            |=> fail_prio_reg ##0 active_reg != 3'h4)
        else $error("Blocked request not flagged");

    a_unconfig_flag: assert property ( // see R20
        (!force_en_reg && |(req_sync_reg & ~enabled)) |=> fail_cfg_reg)
        else $error("Unconfigured request not flagged");

    a_rdata_slot: assert property ( // see R18
        !bus_rd |=> bus_rdata == 32'h0000_0000)
        else $error("Read data outside its slot");

endmodule

/* verif/gps_req_model.sv */
// Request source model: held levels plus timed pulses on the group pins
`timescale 1ns/1ps
module gps_req_model
    import gps_pkg::*;
(
    input wire logic clk_sys,
    input wire gps_mask_t level_mask,
    input wire gps_mask_t pulse_mask,
    input wire logic pulse_go,
    output gps_mask_t group_req
);
    logic [1:0] pulse_cnt_reg = 2'h0;

    // Pulse lasts two clocks, then the pins fall back to the held levels
    always @(posedge clk_sys) begin
        if (pulse_go) begin
            pulse_cnt_reg <= 2'h2;
        end else if (pulse_cnt_reg != 2'h0) begin
            pulse_cnt_reg <= pulse_cnt_reg - 2'h1;
        end
    end

    // Levels and pulses share the pins
    assign group_req = level_mask | ((pulse_cnt_reg != 2'h0) ? pulse_mask : 8'h00);
endmodule

/* verif/tb.sv */
// Self-checking bench of the group priority selector
`timescale 1ns/1ps
`include "gps_regs.svh"
module tb
    import gps_pkg::*;
;
    typedef struct {gps_mask_t req; logic [2:0] code;} gps_row_s;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic [3:0] bus_addr = 4'h0;
    logic [31:0] bus_wdata = 32'h0;
    logic bus_wr = 1'b0;
    logic bus_rd = 1'b0;
    logic [31:0] bus_rdata;
    logic [31:0] d;
    gps_mask_t group_req, group_enabled, load_defaults;
    gps_mask_t level_mask = 8'h00;
    gps_mask_t pulse_mask = 8'h00;
    gps_mask_t seen_ld = 8'h00;
    logic pulse_go = 1'b0;
    logic seen_clr = 1'b0;
    logic [2:0] seen = 3'h0;
    logic [2:0] active_group;
    logic fail_unconfigured, fail_priority, fail_force;
    int miscompares = 0;
    int n_checks = 0;
    gps_row_s rows [7] = '{'{8'h80, 3'h7}, '{8'h01, 3'h0}, '{8'h10, 3'h4}, '{8'h0c, 3'h2},
                           '{8'ha0, 3'h5}, '{8'h40, 3'h6}, '{8'h02, 3'h1}};

    always #25 clk_sys = ~clk_sys;

    gps_req_model gps_req_model_inst (.clk_sys(clk_sys), .level_mask(level_mask),
        .pulse_mask(pulse_mask), .pulse_go(pulse_go), .group_req(group_req));

    gps_selector #(.GROUPS(8)) gps_selector_inst (.clk_sys(clk_sys), .reset(reset),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
        .bus_rdata(bus_rdata), .group_req_in(group_req), .active_group(active_group),
        .group_enabled(group_enabled), .load_defaults(load_defaults),
        .fail_unconfigured(fail_unconfigured), .fail_priority(fail_priority),
        .fail_force(fail_force));

    // Sticky record of flags and default-load pulses
    always @(posedge clk_sys) begin
        if (seen_clr) begin
            seen <= 3'h0;
        end else if (!reset) begin
            seen <= seen | {fail_force, fail_priority, fail_unconfigured};
            seen_ld <= seen_ld | load_defaults;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk_sys);
        bus_addr <= a;
        bus_wdata <= v;
        bus_wr <= 1'b1;
        @(posedge clk_sys);
        bus_wr <= 1'b0;
        wt(3);
    endtask

    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge clk_sys);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge clk_sys);
        bus_rd <= 1'b0;
        #1;
        v = bus_rdata;
    endtask

    task automatic pulse(input gps_mask_t m);
        @(posedge clk_sys);
        pulse_mask <= m;
        pulse_go <= 1'b1;
        @(posedge clk_sys);
        pulse_go <= 1'b0;
        wt(6);
    endtask

    task automatic lv(input gps_mask_t m);
        @(posedge clk_sys);
        level_mask <= m;
        wt(5);
    endtask

    task automatic clr();
        @(posedge clk_sys);
        seen_clr <= 1'b1;
        @(posedge clk_sys);
        seen_clr <= 1'b0;
    endtask

    task automatic close_out();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Watchdog far beyond the expected run
    initial begin
        #(50 * 20000);
        miscompares++;
        close_out();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        wt(6);
        reset <= 1'b0;
        wt(1);
        chk(active_group, 0);
        chk(group_enabled, 8'h01);
        rd(`GPS_OFF_CTRL, d);
        chk(d, 0);
        rd(`GPS_OFF_FORCE, d);
        chk(d, 0);
        rd(`GPS_OFF_REMOTE, d);
        chk(d, 0);
        pulse(8'h04);
        chk(active_group, 0);
        wr(`GPS_OFF_CTRL, 32'h70);
        chk(group_enabled, 8'hff);
        chk(seen_ld, 8'hfe);
        foreach (rows[i]) begin
            pulse(rows[i].req);
            chk(active_group, rows[i].code);
        end
        lv(8'h80);
        chk(active_group, 7);
        lv(8'h88);
        chk(active_group, 3);
        lv(8'h02);
        clr();
        pulse(8'h10);
        chk({seen[1], active_group}, 4'h9);
        lv(8'h03);
        chk(active_group, 0);
        lv(8'h01);
        clr();
        pulse(8'h02);
        chk({seen[1], active_group}, 4'h8);
        lv(8'h00);
        wr(`GPS_OFF_CTRL, 32'h20);
        chk(group_enabled, 8'h07);
        clr();
        pulse(8'h20);
        chk({seen[0], fail_unconfigured, active_group}, 5'h10);
        wr(`GPS_OFF_CTRL, 32'h70);
        wr(`GPS_OFF_FORCE, 32'h3);
        chk({fail_force, active_group}, 4'h8);
        wr(`GPS_OFF_CTRL, 32'h21);
        wr(`GPS_OFF_FORCE, 32'h5);
        chk({fail_force, active_group}, 4'h8);
        rd(`GPS_OFF_FORCE, d);
        chk(d, 0);
        // Operator enables the groups and force before forcing
        wr(`GPS_OFF_CTRL, 32'h71);
        wr(`GPS_OFF_FORCE, 32'h5);
        chk({fail_force, active_group}, 4'h4);
        pulse(8'h01);
        lv(8'h04);
        chk(active_group, 4);
        wr(`GPS_OFF_CTRL, 32'h70);
        chk(active_group, 2);
        lv(8'h00);
        wr(`GPS_OFF_CTRL, 32'h71);
        wr(`GPS_OFF_FORCE, 32'h7);
        wr(`GPS_OFF_CTRL, 32'h70);
        chk(active_group, 6);
        wr(`GPS_OFF_REMOTE, 32'h2);
        chk(active_group, 1);
        lv(8'h04);
        clr();
        wr(`GPS_OFF_REMOTE, 32'h6);
        chk({seen[1], active_group}, 4'ha);
        lv(8'h00);
        wr(`GPS_OFF_REMOTE, 32'h9);
        chk(active_group, 2);
        rd(`GPS_OFF_STATUS, d);
        chk(d, 32'h2);
        wr(4'h2, 32'h77);
        rd(4'h2, d);
        chk(d, 0);
        reset <= 1'b1;
        wt(2);
        reset <= 1'b0;
        wt(1);
        chk({group_enabled, 1'b0, active_group}, 12'h010);
        close_out();
    end
endmodule
